// ---- verilog/hot_plug_pkg.sv ----
// Constants, register map and carriers of the host-port hot plug block
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package hot_plug_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int RETRY_MS = 10;
	localparam int INIT_WAIT_MS = 10;
	localparam int NS_PER_MS = 1000000;
	localparam int RETRY_CYCLES =
		(RETRY_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_WAIT_CYCLES =
		(INIT_WAIT_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 24;

	// Register byte offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_INT_STATUS = 8'h04;
	localparam logic [7:0] OFS_INT_MASK = 8'h08;
	localparam logic [7:0] OFS_DIAGNOSTIC_FIELD = 8'h0C;

	// Event bits of interrupt status and mask
	localparam int EV_NORMAL = 0;
	localparam int EV_LOST = 1;
	localparam int EV_RESTART = 2;
	localparam int EV_PRESENCE = 3;
	localparam int EV_W = 4;

	// Field positions
	localparam int DIAGNOSTIC_FIELD_X_BIT = 0;
	localparam int ST_PORT_EN_BIT = 8;
	localparam int ST_DN_BIT = 16;

	// Host-port machine, one-hot
	typedef enum logic [7:0] {
		NO_COMMUNICATION = 8'h01,
		START_COMMUNICATION = 8'h02,
		WAIT_COMMUNICATION = 8'h04,
		ENABLE_FIRST_PORT = 8'h08,
		FIRST_PORT_INIT = 8'h10,
		FIRST_PORT_INIT_WAIT = 8'h20,
		LEGACY_OK = 8'h40,
		NORMAL_OPERATION = 8'h80
	} host_state_t;

	// Device-port machine, one-hot
	typedef enum logic [1:0] {
		DN_NO_COMMUNICATION = 2'h1,
		DN_COMM_OK = 2'h2
	} dn_state_t;

	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

endpackage : hot_plug_pkg

// ---- verilog/port_multiplier_hot_plug_fsm.sv ----
// Host-port hot plug machine, per-port machines and APB registers
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module port_multiplier_hot_plug_fsm
	import hot_plug_pkg::*;
#(
	parameter int NUM_PORTS = 1,
	parameter int RETRY_CNT = RETRY_CYCLES,
	parameter int INIT_WAIT_CNT = INIT_WAIT_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// APB slave
	input wire apb_req_t apbReq,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Upstream link
	input wire logic hostPhyRdy,
	input wire logic hostInPm,
	input wire logic ctrlFisRx,
	output logic comInitTx,
	output logic selfReset,
	// Downstream ports
	input wire logic [NUM_PORTS-1:0] dnPhyRdy,
	input wire logic first_port_init_state,
	input wire logic port0DetBit0,
	output logic port0Enable,
	output logic presenceChanged,
	// Interrupt
	output logic irq
);

	//////////////////////////////////////////////////////////////////////
	// Elaboration checks
	generate
		if (NUM_PORTS < 1 || NUM_PORTS > 15) begin : badPorts
			$error("NUM_PORTS must be 1 to 15");
		end
		if (RETRY_CNT < 1 || RETRY_CNT >= (1 << TIMER_W)) begin : badRetry
			$error("RETRY_CNT out of timer range");
		end
		if (INIT_WAIT_CNT < 1 || INIT_WAIT_CNT >= (1 << TIMER_W))
		begin : badWait
			$error("INIT_WAIT_CNT out of timer range");
		end
	endgenerate

	localparam logic [TIMER_W-1:0] RETRY_LAST =
		TIMER_W'(RETRY_CNT - 1);
	localparam logic [TIMER_W-1:0] WAIT_LAST =
		TIMER_W'(INIT_WAIT_CNT - 1);

	//////////////////////////////////////////////////////////////////////
	// All state of the block
	typedef struct packed {
		host_state_t host;
		dn_state_t [NUM_PORTS-1:0] dn;
		logic [TIMER_W-1:0] timer;
		logic portEn;
		logic comInit;
		logic rstPulse;
		logic diagX;
		logic [EV_W-1:0] intStat;
		logic [EV_W-1:0] intMask;
		logic irqOut;
		logic ready;
		logic [31:0] rdata;
		logic slverr;
		logic phyS1;
		logic phyS2;
		logic ciS1;
		logic ciS2;
		logic [NUM_PORTS-1:0] dnS1;
		logic [NUM_PORTS-1:0] dnS2;
	} state_t;

	state_t state_reg;
	state_t state_next;

	//////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic established;
		logic lost;
		logic fis;
		logic ci;
		logic timerDone;
		logic waitDone;
		logic access;
		logic doWrite;
		logic [EV_W-1:0] events;
		logic [31:0] rd;
		logic unmapped;
		logic diagSet;
		established = 1'b0;
		lost = 1'b0;
		fis = 1'b0;
		ci = 1'b0;
		timerDone = 1'b0;
		waitDone = 1'b0;
		access = 1'b0;
		doWrite = 1'b0;
		events = '0;
		rd = '0;
		unmapped = 1'b0;
		diagSet = 1'b0;
		state_next = state_reg;

		// Synchronisers; only the second stage is read below
		state_next.phyS1 = hostPhyRdy;
		state_next.phyS2 = state_reg.phyS1;
		state_next.ciS1 = first_port_init_state;
		state_next.ciS2 = state_reg.ciS1;
		state_next.dnS1 = dnPhyRdy;
		state_next.dnS2 = state_reg.dnS1;

		established = state_reg.phyS2;
		lost = !state_reg.phyS2 && !hostInPm;
		fis = ctrlFisRx;
		ci = state_reg.ciS2;
		timerDone = state_reg.timer >= RETRY_LAST;
		waitDone = state_reg.timer >= WAIT_LAST;

		// One-cycle pulses by default
		state_next.comInit = 1'b0;
		state_next.rstPulse = 1'b0;
		state_next.timer = state_reg.timer + TIMER_W'(1);

		case (state_reg.host)
			NO_COMMUNICATION: begin
				// Back to initial state; ports disabled for spinup
				state_next.rstPulse = 1'b1;
				state_next.portEn = 1'b0;
				state_next.diagX = 1'b0;
				state_next.host = START_COMMUNICATION;
			end
			START_COMMUNICATION: begin
				state_next.comInit = 1'b1;
				state_next.timer = '0;
				state_next.host = WAIT_COMMUNICATION;
			end
			WAIT_COMMUNICATION: begin
				if (established) begin
					state_next.host = ENABLE_FIRST_PORT;
				end else if (timerDone) begin
					state_next.host = NO_COMMUNICATION;
				end
			end
			ENABLE_FIRST_PORT: begin
				state_next.portEn = 1'b1;
				state_next.timer = '0;
				if (established) begin
					state_next.host = FIRST_PORT_INIT;
				end else begin
					state_next.host = NO_COMMUNICATION;
				end
			end
			FIRST_PORT_INIT, FIRST_PORT_INIT_WAIT, LEGACY_OK: begin
				if (lost && !fis) begin
					state_next.host = NO_COMMUNICATION;
				end else if (fis) begin
					state_next.host = NORMAL_OPERATION;
					if (port0DetBit0) begin
						state_next.diagX = 1'b1;
						diagSet = 1'b1;
					end
				end else if (state_reg.host == FIRST_PORT_INIT) begin
					// Timer counts from entry into this state until it first saturates; after that it stays at all ones
					if (established && (ci || waitDone)) begin
						state_next.host = FIRST_PORT_INIT_WAIT;
					end
				end else if (state_reg.host == FIRST_PORT_INIT_WAIT) begin
					if (established && !ci) begin
						state_next.host = LEGACY_OK;
						state_next.diagX = 1'b0;
					end
				end else if (ci) begin
					// Here established or in power management
					state_next.host = START_COMMUNICATION;
					state_next.diagX = 1'b1;
					diagSet = 1'b1;
				end
			end
			NORMAL_OPERATION: begin
				if (lost) begin
					state_next.host = NO_COMMUNICATION;
				end
			end
			default: begin
				state_next.host = NO_COMMUNICATION;
			end
		endcase

		// Timer saturates so long waits never wrap
		if (state_reg.timer == '1) begin
			state_next.timer = state_reg.timer;
		end

		// Per-port machines, one loop over all ports
		for (int i = 0; i < NUM_PORTS; i++) begin
			case (state_reg.dn[i])
				DN_NO_COMMUNICATION: begin
					if (state_reg.dnS2[i]) begin
						state_next.dn[i] = DN_COMM_OK;
					end
				end
				DN_COMM_OK: begin
					if (!state_reg.dnS2[i] && !hostInPm) begin
						state_next.dn[i] = DN_NO_COMMUNICATION;
					end
				end
				default: begin
					state_next.dn[i] = DN_NO_COMMUNICATION;
				end
			endcase
		end

		// Events
		events[EV_NORMAL] = state_next.host == NORMAL_OPERATION &&
			state_reg.host != NORMAL_OPERATION;
		events[EV_LOST] = state_next.host == NO_COMMUNICATION &&
			state_reg.host != NO_COMMUNICATION;
		events[EV_RESTART] = state_reg.host == LEGACY_OK &&
			state_next.host == START_COMMUNICATION;
		events[EV_PRESENCE] = state_next.diagX && !state_reg.diagX;

		// APB: one wait state, then answer from flops
		access = apbReq.psel && apbReq.penable;
		doWrite = access && state_reg.ready && apbReq.pwrite;
		state_next.ready = access && !state_reg.ready;

		if (apbReq.paddr == OFS_STATUS) begin
			rd[7:0] = state_reg.host;
			rd[ST_PORT_EN_BIT] = state_reg.portEn;
			for (int i = 0; i < NUM_PORTS; i++) begin
				rd[ST_DN_BIT + i] = state_reg.dn[i] == DN_COMM_OK;
			end
		end else if (apbReq.paddr == OFS_INT_STATUS) begin
			rd[EV_W-1:0] = state_reg.intStat;
		end else if (apbReq.paddr == OFS_INT_MASK) begin
			rd[EV_W-1:0] = state_reg.intMask;
		end else if (apbReq.paddr == OFS_DIAGNOSTIC_FIELD) begin
			rd[DIAGNOSTIC_FIELD_X_BIT] = state_reg.diagX;
		end else begin
			unmapped = 1'b1;
		end

		// Error only flagged alongside its ready pulse
		state_next.slverr = 1'b0;
		if (state_next.ready) begin
			state_next.rdata = apbReq.pwrite ? 32'h0000_0000 : rd;
			state_next.slverr = unmapped;
		end

		// Write one to clear; a same-cycle set wins
		state_next.intStat = state_reg.intStat;
		if (doWrite && apbReq.paddr == OFS_INT_STATUS) begin
			state_next.intStat = state_reg.intStat &
				~apbReq.pwdata[EV_W-1:0];
		end
		state_next.intStat = state_next.intStat | events;

		if (doWrite && apbReq.paddr == OFS_INT_MASK) begin
			state_next.intMask = apbReq.pwdata[EV_W-1:0];
		end

		// Software clears the presence flag unless set now
		if (doWrite && apbReq.paddr == OFS_DIAGNOSTIC_FIELD &&
			apbReq.pwdata[DIAGNOSTIC_FIELD_X_BIT] && !diagSet) begin
			state_next.diagX = 1'b0;
		end

		state_next.irqOut = |(state_next.intStat & state_next.intMask);
	end

	//////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= '0;
			state_reg.host <= NO_COMMUNICATION;
			for (int i = 0; i < NUM_PORTS; i++) begin
				state_reg.dn[i] <= DN_NO_COMMUNICATION;
			end
		end else begin
			state_reg <= state_next;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register
	assign pready = state_reg.ready;
	assign prdata = state_reg.rdata;
	assign pslverr = state_reg.slverr;
	assign comInitTx = state_reg.comInit;
	assign selfReset = state_reg.rstPulse;
	assign port0Enable = state_reg.portEn;
	assign presenceChanged = state_reg.diagX;
	assign irq = state_reg.irqOut;

endmodule : port_multiplier_hot_plug_fsm
`default_nettype wire

// ---- verif/host_link_model.sv ----
// Host controller stand-in on the upstream link
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Bench controls
	input wire logic present,
	input wire logic fisReq,
	input wire logic pmReq,
	input wire logic [3:0] lag,
	// Link
	input wire logic comInitTx,
	output logic hostPhyRdy,
	output logic hostInPm,
	output logic ctrlFisRx
);
	logic [4:0] cnt;
	// Link comes up only in answer to a COMINIT, after a lag
	always_ff @(posedge mclk) begin
		if (!rst_n || !present) begin
			hostPhyRdy <= 1'b0;
			cnt <= 5'h00;
		end else if (comInitTx) begin
			cnt <= {1'b0, lag} + 5'h01;
		end else if (cnt != 5'h00) begin
			cnt <= cnt - 5'h01;
			hostPhyRdy <= hostPhyRdy || (cnt == 5'h01);
		end
	end
	// A FIS is only sent over a live link
	always_ff @(posedge mclk) begin
		ctrlFisRx <= rst_n && fisReq && hostPhyRdy;
		hostInPm <= rst_n && pmReq;
	end
endmodule : host_link_model
`default_nettype wire

// ---- verif/port_multiplier_hot_plug_fsm_asserts.sv ----
// Port checks of the hot plug block
`timescale 1ns/1ps
`default_nettype none
module hot_plug_asserts
	import hot_plug_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// APB
	input wire apb_req_t apbReq,
	input wire logic pready,
	input wire logic pslverr,
	// Link and flags
	input wire logic hostPhyRdy,
	input wire logic hostInPm,
	input wire logic ctrlFisRx,
	input wire logic comInitTx,
	input wire logic selfReset,
	input wire logic port0Enable,
	input wire logic presenceChanged,
	input wire logic irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic acc;
	assign acc = apbReq.psel && apbReq.penable;
	//////////////////////////////////////////////////////////////////////////
	apb_wait_a: assert property (acc && !$past(acc) |-> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	poll_start_a: assert property (selfReset |-> ##1 comInitTx)
		else $error("no COMINIT one cycle after self reset");
	poll_pulse_a: assert property (comInitTx |=> !comInitTx)
		else $error("COMINIT pulse too long");
	reset_clears_a: assert property (selfReset |=>
		!port0Enable && !presenceChanged)
		else $error("self reset left port 0 state");
	enable_cause_a: assert property ($rose(port0Enable) |->
		$past(hostPhyRdy, 3) || $past(hostPhyRdy, 4) || $past(hostPhyRdy, 5))
		else $error("port 0 enabled without PHYRDY");
	// Sync latency is two edges, so six idle cycles must end the link
	link_lost_a: assert property ((port0Enable && !hostPhyRdy &&
		!hostInPm && !ctrlFisRx)[*6] |=> !port0Enable)
		else $error("unplug did not return to no communication");
	cover property ($rose(port0Enable));
	cover property ($rose(presenceChanged));
	cover property ($rose(irq));
endmodule : hot_plug_asserts
bind port_multiplier_hot_plug_fsm hot_plug_asserts i_hot_plug_asserts (
	.mclk(mclk), .rst_n(rst_n), .apbReq(apbReq), .pready(pready),
	.pslverr(pslverr), .hostPhyRdy(hostPhyRdy), .hostInPm(hostInPm),
	.ctrlFisRx(ctrlFisRx), .comInitTx(comInitTx), .selfReset(selfReset),
	.port0Enable(port0Enable), .presenceChanged(presenceChanged),
	.irq(irq));
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench of the hot plug block
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import hot_plug_pkg::*;
;
	localparam int RT = 20;
	logic mclk, rst_n, hostPhyRdy, hostInPm, ctrlFisRx, comInitTx, slvErr;
	logic selfReset, first_port_init_state, port0DetBit0, port0Enable, pslverr;
	logic presenceChanged, irq, pready, present, fisReq, pmReq;
	logic [1:0] dnPhyRdy;
	logic [3:0] lag;
	logic [31:0] prdata, q, rnd;
	logic [4:0] mon;
	apb_req_t req;
	int err_count = 0;
	int n_checks = 0;
	assign mon = {selfReset, irq, presenceChanged, port0Enable, comInitTx};
	port_multiplier_hot_plug_fsm #(.NUM_PORTS(2), .RETRY_CNT(RT),
		.INIT_WAIT_CNT(30)) i_port_multiplier_hot_plug_fsm (.mclk(mclk),
		.rst_n(rst_n), .apbReq(req), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .hostPhyRdy(hostPhyRdy), .hostInPm(hostInPm),
		.ctrlFisRx(ctrlFisRx), .comInitTx(comInitTx), .selfReset(selfReset),
		.dnPhyRdy(dnPhyRdy), .first_port_init_state(first_port_init_state),
		.port0DetBit0(port0DetBit0), .port0Enable(port0Enable),
		.presenceChanged(presenceChanged), .irq(irq));
	host_link_model i_host_link_model (.mclk(mclk), .rst_n(rst_n),
		.present(present), .fisReq(fisReq), .pmReq(pmReq), .lag(lag),
		.comInitTx(comInitTx), .hostPhyRdy(hostPhyRdy),
		.hostInPm(hostInPm), .ctrlFisRx(ctrlFisRx));
	//////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] nxt(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : nxt
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic give_verdict;
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	// Bounded wait on one watched output
	task automatic waitSig(input int b, input logic v);
		int n = 0;
		while (mon[b] !== v) begin
			@(posedge mclk);
			n++;
			if (n > 3000) begin
				err_count++;
				give_verdict;
			end
		end
	endtask : waitSig
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n = 0;
		@(posedge mclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
			if (n > 20) begin
				err_count++;
				give_verdict;
			end
		end while (pready !== 1'b1);
		q = prdata;
		slvErr = pslverr;
		req <= '0;
	endtask : apb
	//////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	initial begin
		int n;
		{rst_n, present, fisReq, pmReq, first_port_init_state, port0DetBit0} = '0;
		req = '0;
		lag = 4'h3;
		dnPhyRdy = 2'h0;
		rnd = 32'hAC53;
		tick(8);
		rst_n <= 1'b1;
		apb(1'b0, OFS_INT_MASK, 32'h0);
		chk(q, 32'h0);
		// Host absent: COMINIT polling period
		waitSig(0, 1'b1);
		@(posedge mclk);
		n = 1;
		while (comInitTx !== 1'b1 && n < 99) begin
			@(posedge mclk);
			n++;
		end
		chk(n, RT + 2);
		present <= 1'b1;
		waitSig(1, 1'b1);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q[8:0], {1'b1, FIRST_PORT_INIT});
		first_port_init_state <= 1'b1;
		tick(8);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q[8:0], {1'b1, FIRST_PORT_INIT_WAIT});
		first_port_init_state <= 1'b0;
		tick(6);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q[8:0], {1'b1, LEGACY_OK});
		// Port 0 COMINIT in legacy mode restarts and interrupts
		apb(1'b1, OFS_INT_STATUS, 32'hF);
		apb(1'b1, OFS_INT_MASK, 32'h8);
		first_port_init_state <= 1'b1;
		waitSig(0, 1'b1);
		chk(presenceChanged, 1'b1);
		waitSig(3, 1'b1);
		apb(1'b1, OFS_INT_MASK, 32'h0);
		tick(2);
		chk(irq, 1'b0);
		apb(1'b1, OFS_INT_MASK, 32'h8);
		tick(2);
		chk(irq, 1'b1);
		apb(1'b1, OFS_INT_STATUS, 32'h8);
		tick(2);
		chk(irq, 1'b0);
		chk(presenceChanged, 1'b1);
		first_port_init_state <= 1'b0;
		tick(6);
		chk(presenceChanged, 1'b0);
		port0DetBit0 <= 1'b1;
		fisReq <= 1'b1;
		@(posedge mclk);
		fisReq <= 1'b0;
		tick(3);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q[8:0], {1'b1, NORMAL_OPERATION});
		chk(presenceChanged, 1'b1);
		apb(1'b0, OFS_DIAGNOSTIC_FIELD, 32'h0);
		chk(q, 32'h1);
		// Power management hides the unplug until it ends
		pmReq <= 1'b1;
		present <= 1'b0;
		tick(8);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q[7:0], NORMAL_OPERATION);
		pmReq <= 1'b0;
		waitSig(4, 1'b1);
		@(posedge mclk);
		chk(presenceChanged, 1'b0);
		rnd = nxt(rnd);
		lag <= rnd[3:0];
		present <= 1'b1;
		waitSig(1, 1'b1);
		// No port 0 COMINIT: only the wait expiry moves on
		tick(20);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q[7:0], FIRST_PORT_INIT);
		tick(8);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q[7:0], LEGACY_OK);
		present <= 1'b0;
		tick(8);
		chk(port0Enable, 1'b0);
		repeat (4) begin
			rnd = nxt(rnd);
			dnPhyRdy <= rnd[1:0];
			tick(5);
			apb(1'b0, OFS_STATUS, 32'h0);
			chk(q[17:16], rnd[1:0]);
		end
		// Reset in mid-run clears every watched output
		rst_n <= 1'b0;
		tick(3);
		chk(mon, 5'h00);
		rst_n <= 1'b1;
		waitSig(4, 1'b1);
		apb(1'b0, 8'h10, 32'h0);
		chk(q, 32'h0);
		chk(slvErr, 1'b1);
		give_verdict;
	end
endmodule : tb_top
`default_nettype wire
